// file: rtl/wwd_core.sv
// Windowed watchdog timer with APB register slave
`timescale 1ns/1ps
`default_nettype none
module wwd_core
  import wwd_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [5:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        watchdog_tick_clock,
  input  wire logic        nvm_enable,
  input  wire logic        nvm_persistent_run,
  input  wire logic        nvm_window_mode,
  input  wire logic [3:0]  nvm_window_sel,
  input  wire logic [3:0]  nvm_timeout_sel,
  input  wire logic [3:0]  nvm_alert_delay,
  output var  logic        sys_reset_req,
  output logic             irq
);

  //----------------------------------------------------------------------
  // Length decode
  //----------------------------------------------------------------------
  // Reserved codes clamp to the longest length rather than wrap
  function automatic logic [15:0] len_of(input logic [3:0] code);
    logic [3:0] c;
    c = (code > WWD_CODE_MAX) ? WWD_CODE_MAX : code;
    return WWD_LEN_BASE << c;
  endfunction

  //----------------------------------------------------------------------
  // State
  //----------------------------------------------------------------------
  logic        load_q;       // First cycle after reset release
  logic        tick_q;       // Previous tick level
  logic        en_q;         // Bus-side enable bit
  logic        wen_q;        // Bus-side window mode bit
  logic        pr_q;         // Bus-side persistent_run bit
  logic [3:0]  win_q;        // Closed window code
  logic [3:0]  per_q;        // Timeout code
  logic [3:0]  ewo_q;        // early_alert_delay code
  logic        en_t_q;       // Enable as seen by the counter
  logic        wen_t_q;      // Window mode as seen by the counter
  logic        pr_t_q;       // persistent_run as seen by the counter
  logic        ctrl_pend_q;  // Control write awaiting a tick
  logic        clr_pend_q;   // Clear write awaiting a tick
  logic [7:0]  clr_val_q;    // Value written to clear
  logic [15:0] cnt_q;        // Ticks since period start
  logic        ea_flag_q;    // early_alert flag
  logic        sd_flag_q;    // domain_sync_done flag
  logic        ea_en_q;      // early_alert interrupt enable

  //----------------------------------------------------------------------
  // Bus decode
  //----------------------------------------------------------------------
  wire logic       setup    = psel & ~penable;
  wire logic       access   = psel & penable;
  wire logic [3:0] idx      = paddr[5:2];
  wire logic       is_ctrl  = (idx == WWD_IDX_CTRL);
  wire logic       is_cfg   = (idx == WWD_IDX_CONFIG);
  wire logic       is_ewc   = (idx == WWD_IDX_EARLY_ALERT_CONTROL_REG);
  wire logic       is_mclr  = (idx == WWD_IDX_MASK_CLR);
  wire logic       is_mset  = (idx == WWD_IDX_MASK_SET);
  wire logic       is_flag  = (idx == WWD_IDX_FLAGS);
  wire logic       is_stat  = (idx == WWD_IDX_STATUS);
  wire logic       is_clr   = (idx == WWD_IDX_CLEAR);
  wire logic       mapped   = is_ctrl | is_cfg | is_ewc | is_mclr | is_mset
                            | is_flag | is_stat | is_clr;
  wire logic       busy     = ctrl_pend_q | clr_pend_q;
  wire logic       sync_acc = access & pwrite & (is_ctrl | is_clr);
  wire logic       prot_acc = access & pwrite & (is_ctrl | is_cfg | is_ewc);
  // Disabling: bit written zero but counter side still running
  wire logic       disabling = ~en_q & en_t_q & ~pr_t_q;
  // Enabled or being enabled blocks protected fields
  wire logic       en_prot   = en_q | en_t_q;

  // Stall a second sync write until the first lands
  // Deferred protected write waits for disable to finish
  assign pready  = ~((sync_acc & busy) | (prot_acc & disabling));
  assign pslverr = access & ~mapped;

  wire logic wr      = access & pwrite & pready & mapped;
  wire logic wr_ctrl = wr & is_ctrl;
  wire logic wr_cfg  = wr & is_cfg & ~en_prot & ~pr_q;
  wire logic wr_ewc  = wr & is_ewc & ~en_prot & ~pr_q;
  wire logic wr_clr  = wr & is_clr;
  wire logic wr_mset = wr & is_mset & pwdata[WWD_FLAG_EA_BIT];
  wire logic wr_mclr = wr & is_mclr & pwdata[WWD_FLAG_EA_BIT];
  wire logic wr_flag = wr & is_flag;

  // Field write permissions within the control register
  wire logic en_ok  = ~pr_q;
  wire logic wen_ok = ~en_prot | pr_q;
  wire logic pr_ok  = ~en_prot;

  //----------------------------------------------------------------------
  // Tick edge and counter decode
  //----------------------------------------------------------------------
  // Tick is slow and taken as synchronous; one edge per rising level
  wire logic        tick_edge = watchdog_tick_clock & ~tick_q;
  wire logic        apply     = tick_edge & busy;
  wire logic        run       = en_t_q | pr_t_q;
  wire logic [15:0] closed_len = wen_t_q ? len_of(win_q) : WWD_RST_CNT;
  wire logic [15:0] total_len  = closed_len + len_of(per_q);
  wire logic [15:0] alert_pt   = wen_t_q ? closed_len : len_of(ewo_q);
  wire logic [15:0] cnt_nx     = cnt_q + 16'h0001;
  wire logic        clr_key  = apply & clr_pend_q & (clr_val_q == WWD_CLEAR_KEY);
  wire logic        clr_bad  = apply & clr_pend_q & (clr_val_q != WWD_CLEAR_KEY);
  wire logic        too_early = clr_key & run & wen_t_q & (cnt_q < closed_len);
  wire logic        timeout_hit = tick_edge & run & (cnt_nx == total_len);
  // An alert point at or past the timeout never fires
  wire logic        alert_hit = tick_edge & run & (cnt_nx == alert_pt)
                              & (alert_pt < total_len);
  wire logic        restart  = ~run | (clr_key & ~too_early) | timeout_hit;

  //----------------------------------------------------------------------
  // Load and tick sampling
  //----------------------------------------------------------------------
  // Straps are caught on the first edge after release, never in reset
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      load_q <= 1'b1;
      tick_q <= 1'b0;
    end
    else
    begin
      load_q <= 1'b0;
      tick_q <= watchdog_tick_clock;
    end

  //----------------------------------------------------------------------
  // Bus-side control and configuration
  //----------------------------------------------------------------------
  // Control bits read back at once; effect waits for a tick
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      en_q  <= WWD_RST_BIT;
      wen_q <= WWD_RST_BIT;
      pr_q  <= WWD_RST_BIT;
    end
    else if (load_q)
    begin
      en_q  <= nvm_enable;
      wen_q <= nvm_window_mode;
      pr_q  <= nvm_persistent_run;
    end
    else if (wr_ctrl)
    begin
      if (en_ok)
        en_q <= pwdata[WWD_CTRL_EN_BIT];
      if (wen_ok)
        wen_q <= pwdata[WWD_CTRL_WEN_BIT];
      // Only a one sticks; power-on alone clears it
      if (pr_ok && pwdata[WWD_CTRL_PR_BIT])
        pr_q <= 1'b1;
    end

  // Timing codes, frozen while enabled or persistent
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      win_q <= WWD_RST_CODE;
      per_q <= WWD_RST_CODE;
      ewo_q <= WWD_RST_CODE;
    end
    else if (load_q)
    begin
      win_q <= nvm_window_sel;
      per_q <= nvm_timeout_sel;
      ewo_q <= nvm_alert_delay;
    end
    else
    begin
      if (wr_cfg)
      begin
        win_q <= pwdata[7:4];
        per_q <= pwdata[3:0];
      end
      if (wr_ewc)
        ewo_q <= pwdata[3:0];
    end

  //----------------------------------------------------------------------
  // Synchronisation pending
  //----------------------------------------------------------------------
  // Set in the write cycle; cleared by the next tick edge
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      ctrl_pend_q <= 1'b0;
      clr_pend_q  <= 1'b0;
      clr_val_q   <= 8'h00;
    end
    else if (wr_ctrl | wr_clr)
    begin
      ctrl_pend_q <= wr_ctrl;
      clr_pend_q  <= wr_clr;
      clr_val_q   <= pwdata[7:0];
    end
    else if (apply)
    begin
      ctrl_pend_q <= 1'b0;
      clr_pend_q  <= 1'b0;
    end

  //----------------------------------------------------------------------
  // Counter-side control copy
  //----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      en_t_q  <= WWD_RST_BIT;
      wen_t_q <= WWD_RST_BIT;
      pr_t_q  <= WWD_RST_BIT;
    end
    else if (load_q)
    begin
      en_t_q  <= nvm_enable;
      wen_t_q <= nvm_window_mode;
      pr_t_q  <= nvm_persistent_run;
    end
    else if (apply && ctrl_pend_q)
    begin
      en_t_q  <= en_q;
      wen_t_q <= wen_q;
      pr_t_q  <= pr_q;
    end

  //----------------------------------------------------------------------
  // Period counter and system reset
  //----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      cnt_q <= WWD_RST_CNT;
    else if (restart)
      cnt_q <= WWD_RST_CNT;
    else if (tick_edge)
      cnt_q <= cnt_nx;

  // Request holds until the reset controller resets this block
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      sys_reset_req <= 1'b0;
    else if (timeout_hit | too_early | clr_bad)
      sys_reset_req <= 1'b1;

  //----------------------------------------------------------------------
  // Flags, mask and interrupt line
  //----------------------------------------------------------------------
  // Hardware set wins over a same-cycle software clear
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      ea_flag_q <= 1'b0;
      sd_flag_q <= 1'b0;
    end
    else
    begin
      ea_flag_q <= alert_hit | (ea_flag_q & ~(wr_flag & pwdata[WWD_FLAG_EA_BIT]));
      sd_flag_q <= apply | (sd_flag_q & ~(wr_flag & pwdata[WWD_FLAG_SD_BIT]));
    end

  // Alert interrupt is off after reset
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      ea_en_q <= 1'b0;
    else if (wr_mset)
      ea_en_q <= 1'b1;
    else if (wr_mclr)
      ea_en_q <= 1'b0;

  assign irq = ea_flag_q & ea_en_q;

  //----------------------------------------------------------------------
  // Read data
  //----------------------------------------------------------------------
  // Captured in the setup cycle so the access phase sees a flop
  wire logic [7:0] rd_ctrl = {pr_q, 4'h0, wen_q, en_q, 1'b0};
  wire logic [7:0] rd_val  = is_ctrl ? rd_ctrl
                           : is_cfg  ? {win_q, per_q}
                           : is_ewc  ? {4'h0, ewo_q}
                           : (is_mclr | is_mset) ? {7'h00, ea_en_q}
                           : is_flag ? {6'h00, sd_flag_q, ea_flag_q}
                           : is_stat ? {busy, 7'h00}
                           : 8'h00;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      prdata <= 32'h00000000;
    else if (setup)
      prdata <= {24'h000000, rd_val};

  //----------------------------------------------------------------------
  // Checks
  //----------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_stall_busy: assert property (sync_acc && busy |-> !pready)
    else $error("sync write not stalled while busy");
  a_busy_set: assert property (wr_ctrl || wr_clr |=> busy)
    else $error("pending not set after sync write");
  a_busy_done: assert property (apply && !wr_ctrl && !wr_clr |=> !busy && sd_flag_q)
    else $error("sync completion missed");
  a_bad_key: assert property (clr_bad |=> sys_reset_req)
    else $error("bad key did not reset");
  a_timeout_rst: assert property (tick_edge && run && cnt_nx == total_len
                                  |=> sys_reset_req && cnt_q == 16'h0000)
    else $error("timeout did not reset");
  a_early_clear: assert property (clr_key && run && wen_t_q && cnt_q < closed_len
                                  |=> sys_reset_req)
    else $error("closed window clear not caught");
  a_pr_sticky: assert property (pr_q |=> pr_q)
    else $error("persistent_run dropped");
  a_cfg_locked: assert property (pr_q && !load_q |=> $stable(per_q) && $stable(ewo_q))
    else $error("timing changed while persistent");
  // Checks the whole path from alert point through flag to the line
  a_irq_level: assert property (alert_hit && ea_en_q && !wr_mclr |=> irq)
    else $error("irq not raised on enabled alert");
  a_no_late_alert: assert property (run && alert_pt >= total_len |=> !$rose(ea_flag_q))
    else $error("alert past timeout");
  a_key_restart: assert property (clr_key && !too_early && run |=> cnt_q == 16'h0000)
    else $error("key did not restart period");

  c_alert: cover property (alert_hit && ea_en_q ##1 irq);
  c_window_ok: cover property (clr_key && run && wen_t_q && cnt_q >= closed_len);
  c_stall: cover property (sync_acc && busy ##1 !busy);
  c_timeout: cover property (timeout_hit);

endmodule // wwd_core
`default_nettype wire

// file: rtl/wwd_pkg.sv
// Constants, register map and field layout of the windowed watchdog timer
//------------------------------------------------------------------------
//------------------------------------------------------------------------
package wwd_pkg;
  // Register indices; byte address is four times the index
  localparam logic [3:0] WWD_IDX_CTRL     = 4'h0;
  localparam logic [3:0] WWD_IDX_CONFIG   = 4'h1;
  localparam logic [3:0] WWD_IDX_EARLY_ALERT_CONTROL_REG   = 4'h2;
  localparam logic [3:0] WWD_IDX_MASK_CLR = 4'h4;
  localparam logic [3:0] WWD_IDX_MASK_SET = 4'h5;
  localparam logic [3:0] WWD_IDX_FLAGS    = 4'h6;
  localparam logic [3:0] WWD_IDX_STATUS   = 4'h7;
  localparam logic [3:0] WWD_IDX_CLEAR    = 4'h8;
  // Field positions
  localparam int WWD_CTRL_EN_BIT  = 1;
  localparam int WWD_CTRL_WEN_BIT = 2;
  localparam int WWD_CTRL_PR_BIT  = 7;
  localparam int WWD_FLAG_EA_BIT  = 0;
  localparam int WWD_FLAG_SD_BIT  = 1;
  localparam int WWD_STAT_BUSY_BIT = 7;
  // Values before the nonvolatile load
  localparam logic       WWD_RST_BIT  = 1'b0;
  localparam logic [3:0] WWD_RST_CODE = 4'h0;
  localparam logic [15:0] WWD_RST_CNT = 16'h0000;
  // Clear key and length encoding
  localparam logic [7:0]  WWD_CLEAR_KEY = 8'hA5;
  localparam logic [15:0] WWD_LEN_BASE  = 16'h0008;
  localparam logic [3:0]  WWD_CODE_MAX  = 4'hB;
endpackage : wwd_pkg

// file: verif/wwd_partner.sv
// Model of the reset and interrupt controllers facing the watchdog
`timescale 1ns/1ps
`default_nettype none
module wwd_partner
(
  input  wire logic pclk,          // Bus clock
  input  wire logic presetn,       // Power-on reset, active low
  input  wire logic sys_reset_req, // Reset request from the watchdog
  input  wire logic irq,           // Shared interrupt line
  output logic      irq_seen,      // Interrupt seen since power-on
  output logic      reset_seen     // Reset request seen since power-on
);
  //----------------------------------------------------------------
  // Event memory
  //----------------------------------------------------------------
  // Only remembers events; the bench judges them, so a short pulse
  // that a level test would miss is still caught here
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_seen   <= 1'b0;
      reset_seen <= 1'b0;
    end
    else
    begin
      irq_seen   <= irq_seen | irq;
      reset_seen <= reset_seen | sys_reset_req;
    end
  end
endmodule // wwd_partner
`default_nettype wire

// file: verif/tb_windowed_watchdog_timer.sv
// Self-checking bench for the windowed watchdog over APB
`timescale 1ns/1ps
`default_nettype none
module tb_windowed_watchdog_timer;
  import wwd_pkg::*;
  logic        pclk    = 1'b0;  // Bus clock, 100 ns
  logic        presetn = 1'b0;  // Power-on reset, active low
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [5:0]  paddr   = 6'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        tick    = 1'b0;  // One rise every four bus cycles
  logic [1:0]  tdiv    = 2'h0;
  logic [15:0] nvm     = 16'h0; // {en,pr,wm,0,win,per,dly}
  logic        sys_reset_req;
  logic        irq;
  logic        irq_seen;
  logic        reset_seen;
  logic [31:0] rd;
  logic        err;
  int          bad_count = 0;
  int          total_checks = 0;
  int          cyc = 0;
  int          n;
  int          nw;              // Wait states of the last transfer

  //----------------------------------------------------------------
  // Clocks, timeout, instances
  //----------------------------------------------------------------
  always #50 pclk = ~pclk;
  // Tick kept two bus cycles high and low, as the core samples it
  always @(posedge pclk)
  begin
    tdiv <= tdiv + 2'h1;
    tick <= tdiv[1];
  end
  // Hang guard, far above the several hundred cycles the run needs
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      bad_count++;
      wrap_up();
    end
  end

  wwd_core uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .watchdog_tick_clock(tick), .nvm_enable(nvm[15]),
    .nvm_persistent_run(nvm[14]), .nvm_window_mode(nvm[13]), .nvm_window_sel(nvm[11:8]),
    .nvm_timeout_sel(nvm[7:4]), .nvm_alert_delay(nvm[3:0]),
    .sys_reset_req(sys_reset_req), .irq(irq));
  wwd_partner far_end (.pclk(pclk), .presetn(presetn), .sys_reset_req(sys_reset_req),
    .irq(irq), .irq_seen(irq_seen), .reset_seen(reset_seen));

  //----------------------------------------------------------------
  // Tasks
  //----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; waits for pready however long the core stalls
  task automatic xfer(input logic [3:0] idx, input logic wr, input logic [7:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    nw = -1;
    do
    begin
      @(posedge pclk);
      nw++;
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] idx, input logic [7:0] wd);
    xfer(idx, 1'b1, wd);
  endtask

  task automatic rdchk(input logic [3:0] idx, input logic [31:0] exp);
    xfer(idx, 1'b0, 8'h00);
    chk(rd, exp);
  endtask

  // Poll busy; bounded so a stuck flag cannot hang the run
  task automatic sync_wait();
    int k;
    k = 0;
    do
    begin
      xfer(WWD_IDX_STATUS, 1'b0, 8'h00);
      k++;
    end
    while (rd[WWD_STAT_BUSY_BIT] !== 1'b0 && k < 50);
  endtask

  // Cycles until reset request or interrupt, at most lim
  task automatic wait_out(input logic want_rst, input int lim);
    n = 0;
    while ((want_rst ? sys_reset_req : irq) !== 1'b1 && n < lim)
    begin
      @(posedge pclk);
      n++;
    end
  endtask

  // Phase the next write so it lands on a tick edge; busy then spans
  // a full tick and the following access is sure to be stalled
  task automatic tick_align();
    do
      @(posedge pclk);
    while (tdiv !== 2'h0);
  endtask

  task automatic power_on(input logic [15:0] v);
    nvm <= v;
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask

  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  //----------------------------------------------------------------
  // Tests
  //----------------------------------------------------------------
  initial
  begin
    // Normal mode straight from power-on values
    power_on(16'h8321);
    rdchk(WWD_IDX_CTRL, 32'h02);
    rdchk(WWD_IDX_CONFIG, 32'h32);
    rdchk(WWD_IDX_EARLY_ALERT_CONTROL_REG, 32'h01);
    rdchk(WWD_IDX_MASK_SET, 32'h00);
    chk(nw, 32'h0);                           // Reads answer with no wait
    xfer(4'h3, 1'b0, 8'h00);
    chk({31'h0, err}, 32'h1);                 // Unmapped index
    wr(WWD_IDX_MASK_SET, 8'h01);
    wait_out(1'b0, 300);
    chk({31'h0, sys_reset_req}, 32'h0);
    chk({31'h0, n > 30 && n < 50}, 32'h1);
    wr(WWD_IDX_FLAGS, 8'h01);
    rdchk(WWD_IDX_FLAGS, 32'h00);
    chk({31'h0, irq}, 32'h0);
    wr(WWD_IDX_MASK_CLR, 8'h01);
    rdchk(WWD_IDX_MASK_SET, 32'h00);
    wait_out(1'b1, 300);
    chk({31'h0, sys_reset_req}, 32'h1);
    $display("test normal done");
    // Alert set beyond the timeout
    power_on(16'h8003);
    wr(WWD_IDX_MASK_SET, 8'h01);
    wait_out(1'b1, 200);
    chk({31'h0, sys_reset_req}, 32'h1);
    chk({31'h0, irq_seen}, 32'h0);
    rdchk(WWD_IDX_FLAGS, 32'h00);
    $display("test late alert done");
    // Disable, deferred config, re-enable, back-to-back sync writes
    power_on(16'h8000);
    tick_align();
    wr(WWD_IDX_CTRL, 8'h00);
    wr(WWD_IDX_CONFIG, 8'h01);
    chk({31'h0, nw > 0}, 32'h1);
    rdchk(WWD_IDX_CONFIG, 32'h01);
    rdchk(WWD_IDX_CTRL, 32'h00);
    sync_wait();
    rdchk(WWD_IDX_FLAGS, 32'h02);
    wr(WWD_IDX_FLAGS, 8'h02);
    repeat (100) @(posedge pclk);
    chk({31'h0, sys_reset_req}, 32'h0);
    tick_align();
    wr(WWD_IDX_CTRL, 8'h02);
    wr(WWD_IDX_CTRL, 8'h02);
    chk({31'h0, nw > 0}, 32'h1);
    chk({31'h0, err}, 32'h0);
    wait_out(1'b1, 100);
    chk({31'h0, sys_reset_req}, 32'h1);
    $display("test enable done");
    // Window mode: alert at open start, clears open and closed
    power_on(16'h2110);
    wr(WWD_IDX_MASK_SET, 8'h01);
    wr(WWD_IDX_CTRL, 8'h06);
    sync_wait();
    wait_out(1'b0, 300);
    chk({31'h0, sys_reset_req}, 32'h0);
    chk({31'h0, n > 40}, 32'h1);
    wr(WWD_IDX_CLEAR, WWD_CLEAR_KEY);
    sync_wait();
    chk({31'h0, reset_seen}, 32'h0);
    wr(WWD_IDX_CLEAR, WWD_CLEAR_KEY);
    wait_out(1'b1, 40);
    chk({31'h0, sys_reset_req}, 32'h1);
    $display("test window done");
    // Persistent run locks timing but keeps mode and mask
    power_on(16'h0000);
    wr(WWD_IDX_CTRL, 8'h80);
    sync_wait();
    rdchk(WWD_IDX_CTRL, 32'h80);
    wr(WWD_IDX_CONFIG, 8'h05);
    rdchk(WWD_IDX_CONFIG, 32'h00);
    wr(WWD_IDX_CTRL, 8'h06);
    sync_wait();
    rdchk(WWD_IDX_CTRL, 32'h84);
    wr(WWD_IDX_MASK_SET, 8'h01);
    rdchk(WWD_IDX_MASK_SET, 32'h01);
    wait_out(1'b1, 200);
    chk({31'h0, sys_reset_req}, 32'h1);
    $display("test persistent done");
    // Wrong key resets even while stopped
    power_on(16'h0000);
    wr(WWD_IDX_CLEAR, 8'h5A);
    wait_out(1'b1, 40);
    chk({31'h0, sys_reset_req}, 32'h1);
    $display("test wrong key done");
    wrap_up();
  end
endmodule // tb_windowed_watchdog_timer
`default_nettype wire
